// [rtl/rcc_pkg.sv]
// Package of constants for the clock control register block
// Contract
// [RULE1] Control register decoded at index 0x04
// [RULE2] Bit 7 enables oscillator, resets zero
// [RULE3] Bit 6 enables missing-clock detector
// [RULE4] Bit 5 fail flag: hardware sets, software clears; code also sets it when software writes a one
// [RULE5] Bit 4 runs timer; zero holds count
// [RULE6] Bit 3 gates alarms; zero clears flag
// [RULE7] Bit 2 read returns live alarm flag
// [RULE8] Bit 2 write sets auto-reset enable
// [RULE9] Bit 1 load request, hardware clears when done
// [RULE10] Bit 0 snapshot request, hardware clears when done
// [RULE11] Alarm flag lasts at most one oscillator cycle; code keeps it set across ticks while a stopped timer stays at the match value
// [RULE12] Running timer increments each oscillator cycle
// [RULE13] Oscillator stuck over 100 us sets fail
// [RULE14] Alarm when timer equals match value
// [RULE15] Auto-reset clears timer cycle after alarm
// [RULE16] Requests and completions crossed between domains; code keeps one aclk domain and acts on synchronised oscillator rising edges
package rcc_pkg;
    // ****************************************
    // Register map (index, byte address = 4 * index)
    // ****************************************
    localparam logic [7:0] CTRL_IDX      = 8'h04;
    localparam logic [7:0] CAP_IDX       = 8'h00;
    localparam logic [7:0] ALARM_IDX     = 8'h08;
    localparam logic [7:0] IRQ_STAT_IDX  = 8'h0C;
    localparam logic [7:0] IRQ_MASK_IDX  = 8'h0D;
    // ****************************************
    // Control field positions
    // ****************************************
    localparam int BIT_OSC_EN   = 7;
    localparam int BIT_MCD_EN   = 6;
    localparam int BIT_FAIL     = 5;
    localparam int BIT_RUN      = 4;
    localparam int BIT_AEN      = 3;
    localparam int BIT_ALARM_FLAG_AUTOCLEAR_SELECT     = 2;
    localparam int BIT_LOAD     = 1;
    localparam int BIT_SNAP     = 0;
    // Interrupt status bits
    localparam int IRQ_ALARM    = 0;
    localparam int IRQ_FAIL     = 1;
    localparam int IRQ_LOAD     = 2;
    localparam int IRQ_SNAP     = 3;
    localparam int IRQ_W        = 4;
    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;
    localparam int          CLK_MHZ     = 125;
    localparam int          MISS_US     = 100;
    localparam int          MISS_CYC    = MISS_US * CLK_MHZ;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : rcc_pkg

// [rtl/rcc_sync.sv]
// Two flip-flop synchroniser for a bundle of levels
`timescale 1ns/10ps
module rcc_sync #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    always_comb
    begin
        meta_d = din;
        out_d  = meta_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            out_q  <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            out_q  <= out_d;
        end
    end

    assign dout = out_q;
endmodule : rcc_sync

// [rtl/rcc_top.sv]
// Clock control register logic with 32-bit timer, alarm and AXI4-Lite slave
`timescale 1ns/10ps
module rcc_top #(
    parameter int MISS_CYC = rcc_pkg::MISS_CYC
) (
    // System clock
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // Write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    // Write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // Write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // Read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    // Read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Oscillator
    input  wire logic        osc_clk_pin,
    output logic             osc_enable,
    // Events
    output logic             alarm_pulse,
    output logic             irq
);
    if (MISS_CYC < 4)
    begin : g_bad_miss
        $error("MISS_CYC too small");
    end

    // ****************************************
    // Oscillator input sampling
    // ****************************************
    // The slow oscillator is sampled on aclk; its rising edges become count enables.
    // Trade-off: one clock domain, timer moves at most once per two aclk edges.
    logic osc_s;
    logic osc_prev_q;
    logic osc_prev_d;
    logic osc_tick;

    rcc_sync #(.W(1)) u_osc_sync (
        .clk   (aclk),
        .rst_n (aresetn),
        .din   (osc_clk_pin),
        .dout  (osc_s)
    );

    // ****************************************
    // Register state
    // ****************************************
    logic        osc_en_q, osc_en_d;
    logic        mcd_en_q, mcd_en_d;
    logic        fail_q, fail_d;
    logic        run_q, run_d;
    logic        aen_q, aen_d;
    logic        autorst_q, autorst_d;
    logic        load_q, load_d;
    logic        snap_q, snap_d;
    logic        alarm_q, alarm_d;
    logic        arst_pend_q, arst_pend_d;
    logic [31:0] timer_q, timer_d;
    logic [31:0] cap_q, cap_d;
    logic [31:0] match_q, match_d;
    logic [31:0] miss_q, miss_d;
    localparam int IRQ_W_L = rcc_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] ist_q, ist_d;
    logic [IRQ_W_L-1:0] imask_q, imask_d;

    // AXI state
    logic        aw_q, aw_d;
    logic        w_q, w_d;
    logic [31:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic        irq_q, irq_d;

    logic        wr_go;
    logic [7:0]  wr_idx;
    logic [7:0]  rd_idx;
    logic [7:0]  ctrl_rd;
    logic [IRQ_W_L-1:0] ev;
    logic        stuck;
    logic        hit;

    assign osc_tick = osc_s & ~osc_prev_q;
    assign wr_go    = aw_q & w_q & ~bvalid_q;
    // Only aligned words in the first kilobyte decode, so no address aliases a register
    assign wr_idx   = (awaddr_q[31:10] == 22'h00_0000 && awaddr_q[1:0] == 2'b00)
                      ? awaddr_q[9:2] : 8'hFF;
    assign rd_idx   = (s_axi_araddr[31:10] == 22'h00_0000 && s_axi_araddr[1:0] == 2'b00)
                      ? s_axi_araddr[9:2] : 8'hFF;
    assign stuck    = (miss_q >= 32'(MISS_CYC) - 32'h0000_0001);
    assign hit      = aen_q & (timer_q == match_q);

    always_comb
    begin
        ctrl_rd = rcc_pkg::CTRL_RST;
        ctrl_rd[rcc_pkg::BIT_OSC_EN] = osc_en_q;
        ctrl_rd[rcc_pkg::BIT_MCD_EN] = mcd_en_q;
        ctrl_rd[rcc_pkg::BIT_FAIL]   = fail_q;
        ctrl_rd[rcc_pkg::BIT_RUN]    = run_q;
        ctrl_rd[rcc_pkg::BIT_AEN]    = aen_q;
        ctrl_rd[rcc_pkg::BIT_ALARM_FLAG_AUTOCLEAR_SELECT]   = alarm_q; // [RULE7]
        ctrl_rd[rcc_pkg::BIT_LOAD]   = load_q;
        ctrl_rd[rcc_pkg::BIT_SNAP]   = snap_q;
    end

    // ****************************************
    // Next state: registers, timer, detector
    // ****************************************
    always_comb
    begin
        osc_prev_d  = osc_s;
        osc_en_d    = osc_en_q;
        mcd_en_d    = mcd_en_q;
        fail_d      = fail_q;
        run_d       = run_q;
        aen_d       = aen_q;
        autorst_d   = autorst_q;
        load_d      = load_q;
        snap_d      = snap_q;
        alarm_d     = alarm_q;
        arst_pend_d = arst_pend_q;
        timer_d     = timer_q;
        cap_d       = cap_q;
        match_d     = match_q;
        miss_d      = miss_q;
        imask_d     = imask_q;
        ev          = '0;

        // Software writes first so hardware sets below win over clears
        if (wr_go && wstrb_q[0])
        begin
            if (wr_idx == rcc_pkg::CTRL_IDX) // [RULE1]
            begin
                osc_en_d  = wdata_q[rcc_pkg::BIT_OSC_EN]; // [RULE2]
                mcd_en_d  = wdata_q[rcc_pkg::BIT_MCD_EN]; // [RULE3]
                fail_d    = wdata_q[rcc_pkg::BIT_FAIL]; // [RULE4]
                run_d     = wdata_q[rcc_pkg::BIT_RUN]; // [RULE5]
                aen_d     = wdata_q[rcc_pkg::BIT_AEN];
                autorst_d = wdata_q[rcc_pkg::BIT_ALARM_FLAG_AUTOCLEAR_SELECT]; // [RULE8]
                if (wdata_q[rcc_pkg::BIT_LOAD])
                    load_d = 1'b1; // [RULE9]
                if (wdata_q[rcc_pkg::BIT_SNAP])
                    snap_d = 1'b1; // [RULE10]
                if (!wdata_q[rcc_pkg::BIT_AEN])
                    alarm_d = 1'b0; // [RULE6]
            end
            else if (wr_idx == rcc_pkg::CAP_IDX)
                cap_d = wdata_q;
            else if (wr_idx == rcc_pkg::ALARM_IDX)
                match_d = wdata_q;
            else if (wr_idx == rcc_pkg::IRQ_MASK_IDX)
                imask_d = wdata_q[IRQ_W_L-1:0];
        end

        // Missing-clock detector: counts aclk cycles since last level change
        if (!mcd_en_q || !osc_en_q || (osc_s != osc_prev_q))
            miss_d = 32'h0000_0000;
        else if (!stuck)
            miss_d = miss_q + 32'h0000_0001;
        if (mcd_en_q && osc_en_q && stuck && !fail_q)
        begin
            fail_d = 1'b1; // [RULE13]
            ev[rcc_pkg::IRQ_FAIL] = 1'b1;
        end

        // Timer domain work happens on oscillator rising edges only
        if (osc_tick)
        begin
            alarm_d = 1'b0; // [RULE11]
            if (arst_pend_q)
            begin
                timer_d     = 32'h0000_0000; // [RULE15]
                arst_pend_d = 1'b0;
            end
            else if (run_q)
                timer_d = timer_q + 32'h0000_0001; // [RULE12]
            if (hit && aen_d)
            begin
                alarm_d     = 1'b1; // [RULE14]
                arst_pend_d = autorst_q;
                ev[rcc_pkg::IRQ_ALARM] = 1'b1;
            end
            // Transfers ride the oscillator edge so the word moves whole
            if (load_q)
            begin
                timer_d = cap_q; // [RULE16]
                load_d  = 1'b0; // [RULE9]
                ev[rcc_pkg::IRQ_LOAD] = 1'b1;
            end
            if (snap_q)
            begin
                cap_d  = timer_q; // [RULE16]
                snap_d = 1'b0; // [RULE10]
                ev[rcc_pkg::IRQ_SNAP] = 1'b1;
            end
        end
        if (!aen_d)
        begin
            alarm_d     = 1'b0; // [RULE6]
            arst_pend_d = 1'b0;
        end
    end

    // ****************************************
    // Interrupt status, write one to clear, set wins
    // ****************************************
    always_comb
    begin
        ist_d = ist_q;
        if (wr_go && wstrb_q[0] && wr_idx == rcc_pkg::IRQ_STAT_IDX)
            ist_d = ist_q & ~wdata_q[IRQ_W_L-1:0];
        ist_d = ist_d | ev;
        irq_d = |(ist_d & imask_d);
    end

    // ****************************************
    // AXI4-Lite next state
    // ****************************************
    always_comb
    begin
        aw_d     = aw_q;
        w_d      = w_q;
        awaddr_d = awaddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_awvalid && !aw_q)
        begin
            aw_d     = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q)
        begin
            w_d     = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_go)
        begin
            bvalid_d = 1'b1;
            if (wr_idx == rcc_pkg::CTRL_IDX || wr_idx == rcc_pkg::CAP_IDX
                || wr_idx == rcc_pkg::ALARM_IDX || wr_idx == rcc_pkg::IRQ_STAT_IDX
                || wr_idx == rcc_pkg::IRQ_MASK_IDX)
                bresp_d = rcc_pkg::RESP_OKAY;
            else
                bresp_d = rcc_pkg::RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
            aw_d     = 1'b0;
            w_d      = 1'b0;
        end
        if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = rcc_pkg::RESP_OKAY;
            rdata_d  = rcc_pkg::WORD_RST;
            if (rd_idx == rcc_pkg::CTRL_IDX)
                rdata_d = {24'h00_0000, ctrl_rd};
            else if (rd_idx == rcc_pkg::CAP_IDX)
                rdata_d = cap_q;
            else if (rd_idx == rcc_pkg::ALARM_IDX)
                rdata_d = match_q;
            else if (rd_idx == rcc_pkg::IRQ_STAT_IDX)
                rdata_d = {28'h000_0000, ist_q};
            else if (rd_idx == rcc_pkg::IRQ_MASK_IDX)
                rdata_d = {28'h000_0000, imask_q};
            else
                rresp_d = rcc_pkg::RESP_SLVERR;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge aclk)
    begin
        // Every reset value is zero, so the whole state clears as one word
        if (!aresetn)
        begin
            {osc_prev_q, osc_en_q, mcd_en_q, fail_q, run_q, aen_q, autorst_q, load_q,
             snap_q, alarm_q, arst_pend_q, timer_q, cap_q, match_q, miss_q, ist_q,
             imask_q, aw_q, w_q, awaddr_q, wdata_q, wstrb_q, bvalid_q, bresp_q,
             rvalid_q, rdata_q, rresp_q, irq_q} <= '0; // [RULE2]
        end
        else if (clk_en)
        begin
            {osc_prev_q, osc_en_q, mcd_en_q, fail_q, run_q, aen_q, autorst_q, load_q,
             snap_q, alarm_q, arst_pend_q, timer_q, cap_q, match_q, miss_q, ist_q,
             imask_q, aw_q, w_q, awaddr_q, wdata_q, wstrb_q, bvalid_q, bresp_q,
             rvalid_q, rdata_q, rresp_q, irq_q}
                <= {osc_prev_d, osc_en_d, mcd_en_d, fail_d, run_d, aen_d, autorst_d, load_d,
                    snap_d, alarm_d, arst_pend_d, timer_d, cap_d, match_d, miss_d, ist_d,
                    imask_d, aw_d, w_d, awaddr_d, wdata_d, wstrb_d, bvalid_d, bresp_d,
                    rvalid_d, rdata_d, rresp_d, irq_d};
        end
    end

    assign s_axi_awready = ~aw_q;
    assign s_axi_wready  = ~w_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign osc_enable    = osc_en_q;
    assign alarm_pulse   = alarm_q;
    assign irq           = irq_q;
endmodule : rcc_top

// [tb/rcc_top_chk.sv]
// Port checker of the clock control block, bound to its top module
`timescale 1ns/10ps
module rcc_top_chk #(
    parameter int MISS_CYC = rcc_pkg::MISS_CYC
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_bvalid,
    // Read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Oscillator and events
    input wire logic        osc_clk_pin,
    input wire logic        osc_enable,
    input wire logic        alarm_pulse,
    input wire logic        irq
);
    // ****************************************
    // Helper logic and properties
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Raw oscillator rises seen while the alarm flag stands; saturates at two
    logic       osc_q, osc_d;
    logic [1:0] rise_q, rise_d;
    always_comb
    begin
        osc_d  = osc_clk_pin;
        rise_d = alarm_pulse ? rise_q + {1'b0, osc_clk_pin & ~osc_q & ~rise_q[1]} : 2'h0;
    end
    always_ff @(posedge aclk)
    begin
        osc_q  <= aresetn ? osc_d : 1'b0;
        rise_q <= aresetn ? rise_d : 2'h0;
    end
    sequence both_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_ctrl_s;
        both_s ##0 (s_axi_awaddr == 32'h0000_0010 && s_axi_wstrb[0]);
    endsequence
    a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
        !s_axi_bvalid && !s_axi_rvalid && !irq && !osc_enable && s_axi_awready)
        else $error("outputs not idle after reset");
    a_write_answer: assert property (both_s |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_write_busy: assert property (both_s |=> !s_axi_awready && !s_axi_wready)
        else $error("write taken while one is held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
        !(s_axi_araddr inside {32'h0000_0000, 32'h0000_0010, 32'h0000_0020,
        32'h0000_0030, 32'h0000_0034}) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_osc_on: assert property (wr_ctrl_s ##0 s_axi_wdata[7] |-> ##[1:3] osc_enable)
        else $error("oscillator not enabled");
    a_osc_off: assert property (wr_ctrl_s ##0 !s_axi_wdata[7] |-> ##[1:3] !osc_enable)
        else $error("oscillator not disabled");
    a_alarm_short: assert property (!rise_q[1])
        else $error("alarm flag outlived an oscillator cycle");
endmodule : rcc_top_chk

bind rcc_top rcc_top_chk #(.MISS_CYC(MISS_CYC)) u_chk (.*);

// [tb/rcc_top_test.sv]
// Self-checking bench of the clock control block
`timescale 1ns/10ps
`define CHK(a, e) \
    begin \
        compares++; \
        if ((a) !== (e)) \
        begin \
            failures++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); \
        end \
    end
module rcc_top_test;
    // ****************************************
    // Signals and design
    // ****************************************
    localparam logic [31:0] A_CTRL = 32'(rcc_pkg::CTRL_IDX) * 4;
    localparam logic [31:0] A_CAP  = 32'(rcc_pkg::CAP_IDX) * 4;
    localparam logic [31:0] A_ALM  = 32'(rcc_pkg::ALARM_IDX) * 4;
    localparam logic [31:0] A_STAT = 32'(rcc_pkg::IRQ_STAT_IDX) * 4;
    localparam logic [31:0] A_MASK = 32'(rcc_pkg::IRQ_MASK_IDX) * 4;
    logic        aclk          = 1'b0;
    logic        aresetn       = 1'b0;
    logic        clk_en        = 1'b1;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    logic        osc_clk_pin   = 1'b0;
    logic [31:0] s_axi_awaddr  = 32'h0000_0000;
    logic [31:0] s_axi_wdata   = 32'h0000_0000;
    logic [31:0] s_axi_araddr  = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb   = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, osc_enable, alarm_pulse, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, v;
    int          failures = 0;
    int          compares = 0;
    int          cycles   = 0;
    int          alarms   = 0;
    // Short stuck-clock limit keeps the detector scenario brief
    rcc_top #(.MISS_CYC(40)) DUT (.*);
    always #4 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cycles++;
        if (alarm_pulse === 1'b1)
            alarms++;
        if (cycles == 20000)
        begin
            failures++;
            end_sim();
        end
    end
    // ****************************************
    // Bus and oscillator tasks
    // ****************************************
    task wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d    = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task w(input logic [31:0] a, input logic [31:0] d);
        wr(a, d, r);
        `CHK(r, rcc_pkg::RESP_OKAY)
    endtask : w
    task rc(input logic [31:0] a, input logic [31:0] e);
        rd(a, v, r);
        `CHK(v, e)
    endtask : rc
    // Slow oscillator: eight system cycles per period, fully synchronised
    task osc(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge aclk);
            osc_clk_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            osc_clk_pin <= 1'b0;
        end
    endtask : osc
    // Raise a self-clearing request and poll it, oscillator running
    task req(input logic [31:0] c, input int b);
        int n;
        n = 0;
        w(A_CTRL, c);
        do
        begin
            osc(1);
            rd(A_CTRL, v, r);
            n++;
        end
        while (v[b] !== 1'b0 && n < 8);
        `CHK(v[b], 1'b0)
    endtask : req
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        rc(A_CTRL, 32'h0000_0000);
        rc(A_CAP, 32'h0000_0000);
        `CHK(osc_enable, 1'b0)
        rd(32'h0000_003C, v, r);
        `CHK(r, rcc_pkg::RESP_SLVERR)
        wr(32'h0000_003C, 32'h0000_00FF, r);
        `CHK(r, rcc_pkg::RESP_SLVERR)
        w(A_CTRL, 32'h0000_0080);
        `CHK(osc_enable, 1'b1)
    endtask : t_reset
    task t_load_count;
        w(A_CAP, 32'h0000_0100);
        req(32'h0000_0082, 1);
        w(A_CAP, 32'h0000_0000);
        req(32'h0000_0081, 0);
        rc(A_CAP, 32'h0000_0100);
        w(A_CTRL, 32'h0000_0090);
        osc(5);
        w(A_CTRL, 32'h0000_0080);
        osc(3);
        req(32'h0000_0081, 0);
        rc(A_CAP, 32'h0000_0105);
    endtask : t_load_count
    task t_fail;
        w(A_CTRL, 32'h0000_00C0);
        repeat (60) @(posedge aclk);
        rd(A_CTRL, v, r);
        `CHK(v[5], 1'b1)
        repeat (60) @(posedge aclk);
        rd(A_CTRL, v, r);
        `CHK(v[5], 1'b1)
        w(A_CTRL, 32'h0000_0080);
        rd(A_CTRL, v, r);
        `CHK(v[5], 1'b0)
    endtask : t_fail
    task t_alarm;
        int c0;
        w(A_CAP, 32'h0000_01FE);
        req(32'h0000_0082, 1);
        w(A_ALM, 32'h0000_0200);
        w(A_MASK, 32'h0000_0001);
        c0 = alarms;
        // Match passes with alarms blocked
        w(A_CTRL, 32'h0000_0094);
        osc(6);
        `CHK(alarms, c0)
        w(A_CTRL, 32'h0000_0080);
        req(32'h0000_0082, 1);
        w(A_CTRL, 32'h0000_009C);
        rd(A_CTRL, v, r);
        `CHK(v[2], 1'b0)
        osc(6);
        `CHK(alarms > c0, 1'b1)
        `CHK(irq, 1'b1)
        w(A_MASK, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        w(A_MASK, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1)
        w(A_STAT, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        req(32'h0000_0081, 0);
        rd(A_CAP, v, r);
        `CHK(v < 32'h0000_0006, 1'b1)
    endtask : t_alarm
    task end_sim;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_load_count();
        t_fail();
        t_alarm();
        end_sim();
    end
endmodule : rcc_top_test
